// *** hw/swm_sleep_wake_ctrl.sv ***
// Purpose: operating mode controller, power-up, sleep and wake sequencing
// Assumes: comparator and spi decode inputs synchronous to clk
// Notes:   reset and interrupt pins are open drain, oe high pulls low
//
// Function
// - supply good loads configuration defaults, then active mode
// - after power-up lin and switches off, watchdog from divider pin strap
// - in active mode config bits enable lin, divider and watchdog
// - active low-power only when every peripheral and spi is idle
// - sleep entered only by a configuration write
// - sleep turns off lin, watchdog, dividers, switches and regulator
// - only lin or ignition wake, or supply loss, leaves sleep
// - lin wake is falling edge, dominant for bus time, rising edge
// - lin wake gives regulator on, transceiver off, slave termination on
// - wake pulls interrupt low and records source in status
// - status returned in same transfer as config write; lin wake reads 11
// - ignition wake reads source bits 10
// - ignition must stay high for debounce time, shorter pulse ignored
// - ignition wake needs no preceding falling edge
// - wake enables regulator, then startup timer holds reset low
// - spi usable only from reset output rising edge
// - lin receiver powered only for a bounded monitoring time
// - after monitor expiry bus must rise above pre-wake high again
// - after a short ends monitoring, a rising edge wakes directly
// - interrupt stays low until the end of the next spi command
`timescale 1ns/1ps
`default_nettype none
`include "swm_defs.svh"
module swm_sleep_wake_ctrl #(
	parameter int unsigned CNT_W       = `SWM_CNT_W,
	parameter int unsigned STARTUP_CYC = `SWM_T_STARTUP_US * `SWM_CLK_MHZ,
	parameter int unsigned BUS_CYC     = `SWM_T_BUS_US * `SWM_CLK_MHZ,
	parameter int unsigned MON_CYC     = `SWM_T_MON_US * `SWM_CLK_MHZ,
	parameter int unsigned DEB_CYC     = `SWM_T_IGN_DEB_US * `SWM_CLK_MHZ
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        supplyOk,
	input  wire logic        vccValid,
	input  wire logic        linDominant,
	input  wire logic        linAbovePreHigh,
	input  wire logic        ignitionWakeIn,
	input  wire logic        dividerPinLevel,
	input  wire logic        cfgWrStb,
	input  wire logic        cfgSleepReq,
	input  wire logic        cfgLinEnable,
	input  wire logic        cfgDividerEnable,
	input  wire logic        cfgWatchdogDisable,
	input  wire logic        cfgCurrentSourceEnable,
	input  wire logic        cfgCurrentSourceStaticOn,
	input  wire logic        sourcePulseIn,
	input  wire logic        spiSelectN,
	input  wire logic        spiFrameEnd,
	input  wire logic        resetOutNIn,
	input  wire logic        irqOutNIn,
	output logic             regulatorEnable,
	output logic             linTransceiverEnable,
	output logic             dividerEnable,
	output logic             watchdogRun,
	output logic             switchIfEnable,
	output logic             slaveTermOn,
	output logic             linRxMonitor,
	output logic             resetOutNOut,
	output logic             resetOutNOe,
	output logic             irqOutNOut,
	output logic             irqOutNOe,
	output logic             spiReady,
	output logic             irqSourceHi,
	output logic             irqSourceLo,
	output logic             irqPinLow,
	output logic             activeLowPower,
	output swm_pkg::swm_mode_t modeState
);
	import swm_pkg::*;

	swm_wake_if              wk ();

	swm_mode_t               mode_r;
	logic [CNT_W-1:0]        holdCnt_r;
	logic                    linEn_r;
	logic                    divEn_r;
	logic                    csEn_r;
	logic                    csStatic_r;
	logic                    wdDis_r;
	logic                    regulatorEnable_r;
	logic                    linTransceiverEnable_r;
	logic                    dividerEnable_r;
	logic                    watchdogRun_r;
	logic                    switchIfEnable_r;
	logic                    slaveTermOn_r;
	logic                    linRxMonitor_r;
	logic                    resetOutNOe_r;
	logic                    irqPend_r;
	logic                    spiReady_r;
	logic                    irqSourceHi_r;
	logic                    irqSourceLo_r;
	logic                    irqPinLow_r;
	logic                    activeLowPower_r;
	logic                    zero_r;
	logic                    cfgAccept;
	logic                    sleepCmd;
	logic                    wakeLin;
	logic                    wakeIgn;
	logic                    reportDone;
	logic                    isActive;
	logic                    isPowered;
	logic                    srcLoad;

	// wake detection lives in its own module, only armed in sleep
	swm_wake_detect #(
		.CNT_W   (CNT_W),
		.BUS_CYC (BUS_CYC),
		.MON_CYC (MON_CYC),
		.DEB_CYC (DEB_CYC)
	) u_detect (
		.clk             (clk),
		.arst_n          (arst_n),
		.linDominant     (linDominant),
		.linAbovePreHigh (linAbovePreHigh),
		.ignitionWakeIn  (ignitionWakeIn),
		.wk              (wk.det)
	);

	assign wk.sleepEn = (mode_r == ST_SLEEP);

	// qualified events
	assign isActive   = (mode_r == ST_ACTIVE);
	assign isPowered  = (mode_r == ST_RAMP) || (mode_r == ST_HOLD) || isActive;
	assign cfgAccept  = cfgWrStb && spiReady_r;
	assign sleepCmd   = cfgAccept && cfgSleepReq;
	assign wakeLin    = wk.sleepEn && wk.linWake;
	assign wakeIgn    = wk.sleepEn && wk.ignWake && !wk.linWake;
	assign reportDone = spiFrameEnd && spiReady_r;
	assign srcLoad    = wakeLin || wakeIgn;

	// mode sequencer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r    <= ST_OFF;
			holdCnt_r <= '0;
		end else if (!supplyOk) begin
			mode_r    <= ST_OFF;
			holdCnt_r <= '0;
		end else begin
			case (mode_r)
				ST_OFF: begin
					mode_r <= ST_RAMP;
				end
				ST_RAMP: begin
					holdCnt_r <= '0;
					if (vccValid) begin
						mode_r <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					holdCnt_r <= holdCnt_r + 1'b1;
					if (!vccValid) begin
						mode_r <= ST_RAMP;
					end else if (holdCnt_r == CNT_W'(STARTUP_CYC - 1)) begin
						mode_r <= ST_ACTIVE;
					end
				end
				ST_ACTIVE: begin
					// undervoltage on vcc restarts the reset hold
					if (!vccValid) begin
						mode_r <= ST_RAMP;
					end else if (sleepCmd) begin
						mode_r <= ST_SLEEP;
					end
				end
				default: begin
					if (srcLoad) begin
						mode_r <= ST_RAMP;
					end
				end
			endcase
		end
	end

	// configuration bits: defaults at power-up, strap during reset hold
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			linEn_r    <= `SWM_RST_LIN_EN;
			divEn_r    <= `SWM_RST_DIV_EN;
			csEn_r     <= `SWM_RST_CS_EN;
			csStatic_r <= `SWM_RST_CS_STATIC;
			wdDis_r    <= `SWM_RST_WD_DIS;
		end else if (mode_r == ST_OFF) begin
			linEn_r    <= `SWM_RST_LIN_EN;
			divEn_r    <= `SWM_RST_DIV_EN;
			csEn_r     <= `SWM_RST_CS_EN;
			csStatic_r <= `SWM_RST_CS_STATIC;
			wdDis_r    <= `SWM_RST_WD_DIS;
		end else if (mode_r == ST_RAMP || mode_r == ST_HOLD) begin
			wdDis_r <= dividerPinLevel;
		end else if (sleepCmd) begin
			// woken part comes back with lin and switches off
			linEn_r <= 1'b0;
			divEn_r <= 1'b0;
			csEn_r  <= 1'b0;
		end else if (cfgAccept && isActive) begin
			linEn_r    <= cfgLinEnable;
			divEn_r    <= cfgDividerEnable;
			csEn_r     <= cfgCurrentSourceEnable;
			csStatic_r <= cfgCurrentSourceStaticOn;
			wdDis_r    <= cfgWatchdogDisable;
		end
	end

	// peripheral enables follow mode and configuration
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regulatorEnable_r      <= 1'b0;
			linTransceiverEnable_r <= 1'b0;
			dividerEnable_r        <= 1'b0;
			watchdogRun_r          <= 1'b0;
			switchIfEnable_r       <= 1'b0;
			slaveTermOn_r          <= 1'b0;
			linRxMonitor_r         <= 1'b0;
		end else begin
			regulatorEnable_r      <= isPowered;
			linTransceiverEnable_r <= isActive && linEn_r;
			dividerEnable_r        <= isActive && divEn_r;
			watchdogRun_r          <= isActive && !wdDis_r;
			switchIfEnable_r       <= isActive && csEn_r && (csStatic_r || sourcePulseIn);
			slaveTermOn_r          <= isPowered;
			linRxMonitor_r         <= wk.sleepEn && wk.rxOn;
		end
	end

	// low-power flag: any running peripheral or spi select spoils it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			activeLowPower_r <= 1'b0;
		end else begin
			activeLowPower_r <= isActive && !linEn_r && !divEn_r && wdDis_r && spiSelectN
				&& !(csEn_r && (csStatic_r || sourcePulseIn));
		end
	end

	// reset output held low outside active; spi opens after the pin rises
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			resetOutNOe_r <= 1'b1;
			spiReady_r    <= 1'b0;
		end else begin
			resetOutNOe_r <= !isActive;
			// a slow external pull-up delays spi, never the reverse
			spiReady_r    <= isActive && !resetOutNOe_r && resetOutNIn;
		end
	end

	// wake source latch; a new wake wins over a same-cycle report
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqSourceHi_r <= 1'b0;
			irqSourceLo_r <= 1'b0;
		end else if (wakeLin) begin
			{irqSourceHi_r, irqSourceLo_r} <= `SWM_SRC_LIN;
		end else if (wakeIgn) begin
			{irqSourceHi_r, irqSourceLo_r} <= `SWM_SRC_IGN;
		end else if (reportDone) begin
			{irqSourceHi_r, irqSourceLo_r} <= `SWM_SRC_NONE;
		end
	end

	// interrupt request until the frame that carries the source ends
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqPend_r <= 1'b0;
		end else if (srcLoad) begin
			irqPend_r <= 1'b1;
		end else if (reportDone) begin
			irqPend_r <= 1'b0;
		end
	end

	// pin readback and constant low drive level of the open-drain pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqPinLow_r <= 1'b0;
			zero_r      <= 1'b0;
		end else begin
			irqPinLow_r <= !irqOutNIn;
			zero_r      <= 1'b0;
		end
	end

	assign regulatorEnable      = regulatorEnable_r;
	assign linTransceiverEnable = linTransceiverEnable_r;
	assign dividerEnable        = dividerEnable_r;
	assign watchdogRun          = watchdogRun_r;
	assign switchIfEnable       = switchIfEnable_r;
	assign slaveTermOn          = slaveTermOn_r;
	assign linRxMonitor         = linRxMonitor_r;
	assign resetOutNOut         = zero_r;
	assign resetOutNOe          = resetOutNOe_r;
	assign irqOutNOut           = zero_r;
	assign irqOutNOe            = irqPend_r;
	assign spiReady             = spiReady_r;
	assign irqSourceHi          = irqSourceHi_r;
	assign irqSourceLo          = irqSourceLo_r;
	assign irqPinLow            = irqPinLow_r;
	assign activeLowPower       = activeLowPower_r;
	assign modeState            = mode_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence sEnterSleep;
		mode_r != ST_SLEEP ##1 mode_r == ST_SLEEP;
	endsequence
	sequence sLeaveSleep;
		mode_r == ST_SLEEP ##1 mode_r != ST_SLEEP;
	endsequence
	sequence sLinWake;
		mode_r == ST_SLEEP && wk.linWake;
	endsequence

	AST_SLEEP_ON_CMD: assert property (sEnterSleep |-> $past(sleepCmd))
		else $error("sleep entered without command");
	AST_SLEEP_OFF: assert property ((mode_r == ST_SLEEP) [*2] |-> !regulatorEnable_r
		&& !linTransceiverEnable_r && !watchdogRun_r && !dividerEnable_r && !switchIfEnable_r)
		else $error("peripheral on during sleep");
	AST_WAKE_ONLY: assert property (sLeaveSleep |-> $past(wk.linWake || wk.ignWake || !supplyOk))
		else $error("sleep left without wake");
	AST_LIN_SRC: assert property (sLinWake |=> {irqSourceHi_r, irqSourceLo_r} == `SWM_SRC_LIN
		&& irqPend_r && !linEn_r)
		else $error("lin wake source not recorded");
	AST_IGN_SRC: assert property (wakeIgn |=> {irqSourceHi_r, irqSourceLo_r} == `SWM_SRC_IGN)
		else $error("ignition wake source not recorded");
	AST_IRQ_SET: assert property (srcLoad |=> irqOutNOe ##1 mode_r == ST_RAMP || !supplyOk)
		else $error("wake without interrupt");
	AST_IRQ_HOLD: assert property (irqPend_r && !reportDone && !srcLoad |=> irqPend_r)
		else $error("interrupt released before frame end");
	AST_RESET_HOLD: assert property (mode_r == ST_HOLD |=> resetOutNOe_r)
		else $error("reset released during startup hold");
	AST_SPI_AFTER_RESET: assert property ($rose(spiReady_r) |-> $past(resetOutNIn && !resetOutNOe_r))
		else $error("spi ready before reset rising edge");
	AST_LOWPOWER: assert property (activeLowPower_r |-> !linTransceiverEnable_r && !dividerEnable_r
		&& !watchdogRun_r && !switchIfEnable_r && regulatorEnable_r)
		else $error("low power with peripheral on");
	AST_STRAP: assert property (mode_r == ST_HOLD && supplyOk |=> wdDis_r == $past(dividerPinLevel))
		else $error("watchdog strap not sampled");
endmodule : swm_sleep_wake_ctrl
`default_nettype wire

// *** hw/swm_defs.svh ***
// Purpose: constants of the sleep/wake mode controller
// Assumes: 100 MHz clock
// Notes:   times in microseconds, cycle counts derived in the modules
`ifndef SWM_DEFS_SVH
`define SWM_DEFS_SVH
`define SWM_CLK_MHZ        100
`define SWM_T_STARTUP_US   4000
`define SWM_T_IGN_DEB_US   160
`define SWM_T_BUS_US       100
`define SWM_T_MON_US       10000
`define SWM_CNT_W          24
`define SWM_SRC_NONE       2'h0
`define SWM_SRC_IGN        2'h2
`define SWM_SRC_LIN        2'h3
`define SWM_RST_LIN_EN     1'h0
`define SWM_RST_DIV_EN     1'h0
`define SWM_RST_CS_EN      1'h0
`define SWM_RST_CS_STATIC  1'h0
`define SWM_RST_WD_DIS     1'h0
`endif

// *** hw/swm_pkg.sv ***
// Purpose: types of the sleep/wake mode controller
// Assumes: constants live in swm_defs.svh
// Notes:   none
package swm_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_RAMP, ST_HOLD, ST_ACTIVE, ST_SLEEP} swm_mode_t;
	typedef enum logic [1:0] {LW_IDLE, LW_MON, LW_LOCK} swm_lin_t;
endpackage : swm_pkg

// *** hw/swm_wake_if.sv ***
// Purpose: carrier between mode controller and wake detector
// Assumes: single clock
// Notes:   wake strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface swm_wake_if;
	logic sleepEn;
	logic linWake;
	logic ignWake;
	logic rxOn;
	modport det (input sleepEn, output linWake, output ignWake, output rxOn);
	modport ctl (output sleepEn, input linWake, input ignWake, input rxOn);
endinterface : swm_wake_if
`default_nettype wire

// *** hw/swm_wake_detect.sv ***
// Purpose: lin and ignition wake detection during sleep
// Assumes: bus comparator levels synchronous to clk
// Notes:   all state except shortSeen_r and prevDom_r cleared while not asleep
`timescale 1ns/1ps
`default_nettype none
`include "swm_defs.svh"
module swm_wake_detect #(
	parameter int unsigned CNT_W   = `SWM_CNT_W,
	parameter int unsigned BUS_CYC = `SWM_T_BUS_US * `SWM_CLK_MHZ,
	parameter int unsigned MON_CYC = `SWM_T_MON_US * `SWM_CLK_MHZ,
	parameter int unsigned DEB_CYC = `SWM_T_IGN_DEB_US * `SWM_CLK_MHZ
) (
	input  wire logic     clk,
	input  wire logic     arst_n,
	input  wire logic     linDominant,
	input  wire logic     linAbovePreHigh,
	input  wire logic     ignitionWakeIn,
	swm_wake_if.det       wk
);
	import swm_pkg::*;

	swm_lin_t             linSt_r;
	logic [CNT_W-1:0]     monCnt_r;
	logic [CNT_W-1:0]     domCnt_r;
	logic [CNT_W-1:0]     ignCnt_r;
	logic                 prevDom_r;
	logic                 shortSeen_r;
	logic                 linWake_r;
	logic                 ignWake_r;

	assign wk.linWake = linWake_r;
	assign wk.ignWake = ignWake_r;
	assign wk.rxOn    = (linSt_r == LW_MON);

	// previous bus level, reset dominant so entry is never an edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prevDom_r <= 1'b1;
		end else begin
			prevDom_r <= linDominant;
		end
	end

	// lin monitor: receiver only powered for a bounded window
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			linSt_r     <= LW_IDLE;
			monCnt_r    <= '0;
			domCnt_r    <= '0;
			shortSeen_r <= 1'b0;
			linWake_r   <= 1'b0;
		end else if (!wk.sleepEn) begin
			linSt_r   <= LW_IDLE;
			monCnt_r  <= '0;
			domCnt_r  <= '0;
			linWake_r <= 1'b0;
		end else begin
			linWake_r <= 1'b0;
			case (linSt_r)
				LW_IDLE: begin
					monCnt_r <= '0;
					domCnt_r <= '0;
					if (!linAbovePreHigh) begin
						linSt_r <= LW_MON;
					end
				end
				LW_MON: begin
					monCnt_r <= monCnt_r + 1'b1;
					if (!linDominant && prevDom_r && domCnt_r >= CNT_W'(BUS_CYC)) begin
						linWake_r <= 1'b1;
						linSt_r   <= LW_IDLE;
					end else if (monCnt_r == CNT_W'(MON_CYC - 1)) begin
						linSt_r     <= LW_LOCK;
						shortSeen_r <= linDominant;
					end else if (linAbovePreHigh && !linDominant) begin
						linSt_r <= LW_IDLE;
					end
					// dominant time only counts after a falling edge
					if (linDominant && !prevDom_r) begin
						domCnt_r <= CNT_W'(1);
					end else if (linDominant && domCnt_r != '0 && domCnt_r != '1) begin
						domCnt_r <= domCnt_r + 1'b1;
					end else if (!linDominant) begin
						domCnt_r <= '0;
					end
				end
				default: begin
					// bus must come back above pre-wake high first
					if (linAbovePreHigh) begin
						linWake_r <= shortSeen_r;
						linSt_r   <= LW_IDLE;
					end
				end
			endcase
		end
	end

	// ignition debounce: level alone, no edge needed
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ignCnt_r  <= '0;
			ignWake_r <= 1'b0;
		end else begin
			ignWake_r <= 1'b0;
			if (!wk.sleepEn || !ignitionWakeIn) begin
				ignCnt_r <= '0;
			end else if (ignCnt_r != CNT_W'(DEB_CYC)) begin
				ignCnt_r <= ignCnt_r + 1'b1;
				if (ignCnt_r == CNT_W'(DEB_CYC - 1)) begin
					ignWake_r <= 1'b1;
				end
			end
		end
	end

	AST_IGN_DEBOUNCE: assert property (@(posedge clk) disable iff (!arst_n)
		ignWake_r |-> $past(ignCnt_r) == CNT_W'(DEB_CYC - 1) && $past(ignitionWakeIn))
		else $error("ignition wake before debounce time");
	AST_MON_LIMIT: assert property (@(posedge clk) disable iff (!arst_n)
		linSt_r == LW_MON |-> monCnt_r < CNT_W'(MON_CYC))
		else $error("lin monitor window overran");
	AST_LOCK_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
		linSt_r == LW_LOCK && !linAbovePreHigh && wk.sleepEn |=> !linWake_r)
		else $error("lin wake while locked below pre-wake high");
endmodule : swm_wake_detect
`default_nettype wire

// *** verif/swm_host_model.sv ***
// Purpose: far side of the mode controller: pin pull-ups and regulator output
// Assumes: one clock, open-drain reset and interrupt pins with pull-ups
// Notes:   regulator output settles a few cycles after enable
`timescale 1ns/1ps
`default_nettype none
module swm_host_model #(
	parameter int unsigned RAMP_CYC = 3
) (
	input  wire logic clk,
	input  wire logic regulatorEnable,
	input  wire logic resetOutNOe,
	input  wire logic irqOutNOe,
	output logic      vccValid,
	output logic      resetOutNIn,
	output logic      irqOutNIn
);
	logic [3:0] rampCnt_r = 4'h0;
	// pull-ups win unless the device pulls the pin low
	assign resetOutNIn = !resetOutNOe;
	assign irqOutNIn   = !irqOutNOe;
	assign vccValid    = (rampCnt_r == RAMP_CYC[3:0]);
	// output drops at once when the regulator is switched off
	always_ff @(posedge clk) begin
		if (!regulatorEnable) begin
			rampCnt_r <= 4'h0;
		end else if (rampCnt_r != RAMP_CYC[3:0]) begin
			rampCnt_r <= rampCnt_r + 4'h1;
		end
	end
endmodule : swm_host_model
`default_nettype wire

// *** verif/swm_sleep_wake_ctrl_tb_top.sv ***
// Purpose: self-checking bench of the mode controller
// Assumes: short counts set by parameters
// Notes:   config bits packed as {sleep, lin, div, wdDis, csEn, csStatic}
`timescale 1ns/1ps
`default_nettype none
module swm_sleep_wake_ctrl_tb_top;
	import swm_pkg::*;
	localparam int unsigned STARTUP = 20;
	localparam int unsigned BUS = 5;
	localparam int unsigned MON = 50;
	localparam int unsigned DEB = 8;
	logic clk = 1'b0, arst_n = 1'b0, supplyOk = 1'b1, linAbovePreHigh = 1'b1, spiSelectN = 1'b1;
	logic dividerPinLevel = 1'b1, linDominant = 1'b0, ignitionWakeIn = 1'b0, sourcePulseIn = 1'b0;
	logic cfgWrStb = 1'b0, cfgSleepReq = 1'b0, cfgLinEnable = 1'b0, cfgDividerEnable = 1'b0;
	logic cfgWatchdogDisable = 1'b0, cfgCurrentSourceEnable = 1'b0, cfgCurrentSourceStaticOn = 1'b0;
	logic spiFrameEnd = 1'b0, vccValid, resetOutNIn, irqOutNIn;
	logic regulatorEnable, linTransceiverEnable, dividerEnable, watchdogRun, switchIfEnable, slaveTermOn;
	logic linRxMonitor, resetOutNOut, resetOutNOe, irqOutNOut, irqOutNOe, spiReady;
	logic irqSourceHi, irqSourceLo, irqPinLow, activeLowPower;
	swm_mode_t modeState;
	int errTotal = 0;
	int nChecks = 0;
	logic [5:0] cfgTab [7] = '{6'h14, 6'h0C, 6'h00, 6'h07, 6'h06, 6'h1B, 6'h04};
	logic [4:0] expTab [7] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h1E, 5'h01};
	always #5 clk = ~clk;
	swm_sleep_wake_ctrl #(.STARTUP_CYC(STARTUP), .BUS_CYC(BUS), .MON_CYC(MON), .DEB_CYC(DEB)) u_swm_sleep_wake_ctrl (
		.clk, .arst_n, .supplyOk, .vccValid, .linDominant, .linAbovePreHigh, .ignitionWakeIn, .dividerPinLevel,
		.cfgWrStb, .cfgSleepReq, .cfgLinEnable, .cfgDividerEnable, .cfgWatchdogDisable, .cfgCurrentSourceEnable,
		.cfgCurrentSourceStaticOn, .sourcePulseIn, .spiSelectN, .spiFrameEnd, .resetOutNIn, .irqOutNIn,
		.regulatorEnable, .linTransceiverEnable, .dividerEnable, .watchdogRun, .switchIfEnable, .slaveTermOn,
		.linRxMonitor, .resetOutNOut, .resetOutNOe, .irqOutNOut, .irqOutNOe, .spiReady, .irqSourceHi,
		.irqSourceLo, .irqPinLow, .activeLowPower, .modeState);
	swm_host_model u_swm_host_model (.clk, .regulatorEnable, .resetOutNOe, .irqOutNOe, .vccValid, .resetOutNIn,
		.irqOutNIn);
	task automatic summarize;
		if (errTotal == 0 && nChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		nChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	// settle one step past the edge so sampled outputs are final
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic cfgWrite(input logic [5:0] b);
		@(posedge clk);
		{cfgSleepReq, cfgLinEnable, cfgDividerEnable, cfgWatchdogDisable, cfgCurrentSourceEnable,
			cfgCurrentSourceStaticOn} <= b;
		cfgWrStb <= 1'b1;
		@(posedge clk);
		cfgWrStb <= 1'b0;
		tick(3);
	endtask : cfgWrite
	// bounded wait; a stuck mode ends the run
	task automatic waitMode(input swm_mode_t m, input int lim);
		int i;
		for (i = 0; i < lim && modeState !== m; i++) begin
			tick(1);
			if (resetOutNOe === 1'b1 && spiReady === 1'b1) chk("spiInReset", 0, 1);
		end
		if (modeState !== m) begin
			chk("modeWait", m, modeState);
			summarize();
		end
	endtask : waitMode
	task automatic bootChk;
		int n;
		waitMode(ST_HOLD, 10);
		for (n = 0; n < 40 && modeState === ST_HOLD; n++) tick(1);
		chk("holdCycles", STARTUP, n);
		chk("rstHeld", 1, resetOutNOe);
		tick(2);
		chk("spiReady", 1, spiReady);
		chk("rstPin", 1, resetOutNIn);
	endtask : bootChk
	task automatic wakeChk(input logic [1:0] src);
		waitMode(ST_RAMP, MON + 20);
		chk("irqOe", 1, irqOutNOe);
		chk("srcWake", src, {irqSourceHi, irqSourceLo});
		bootChk();
		chk("srcLatched", src, {irqSourceHi, irqSourceLo});
		chk("irqPinLow", 1, irqPinLow);
		chk("wakeOut", 3'h5, {regulatorEnable, linTransceiverEnable, slaveTermOn});
		@(posedge clk);
		spiFrameEnd <= 1'b1;
		// frame end not yet sampled, pin must still be held
		#1;
		chk("irqHeld", 1, irqOutNOe);
		@(posedge clk);
		spiFrameEnd <= 1'b0;
		tick(0);
		chk("irqFree", 0, irqOutNOe);
		chk("srcClear", 0, {irqSourceHi, irqSourceLo});
	endtask : wakeChk
	// enable peripherals first so the sleep write really has to turn them off
	task automatic goSleep;
		cfgWrite(6'h1B);
		cfgWrite(6'h20);
		chk("sleep", ST_SLEEP, modeState);
		chk("sleepOff", 0, {regulatorEnable, linTransceiverEnable, dividerEnable, watchdogRun, switchIfEnable});
	endtask : goSleep
	initial begin
		repeat (20000) @(posedge clk);
		errTotal++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		bootChk();
		chk("bootMode", ST_ACTIVE, modeState);
		chk("bootOut", 3'h1, {linTransceiverEnable, switchIfEnable, activeLowPower});
		chk("wdStrap", 0, watchdogRun);
		for (int k = 0; k < 7; k++) begin
			cfgWrite(cfgTab[k]);
			chk("periph", expTab[k], {linTransceiverEnable, dividerEnable, watchdogRun, switchIfEnable, activeLowPower});
		end
		cfgWrite(6'h06);
		@(posedge clk);
		sourcePulseIn <= 1'b1;
		tick(3);
		chk("pulseSw", 2'h2, {switchIfEnable, activeLowPower});
		@(posedge clk);
		sourcePulseIn <= 1'b0;
		spiSelectN <= 1'b0;
		tick(3);
		chk("selLp", 0, activeLowPower);
		spiSelectN <= 1'b1;
		goSleep();
		cfgWrite(6'h10);
		sourcePulseIn <= 1'b1;
		tick(20);
		chk("noWake", ST_SLEEP, modeState);
		chk("noLin", 0, linTransceiverEnable);
		sourcePulseIn <= 1'b0;
		ignitionWakeIn <= 1'b1;
		repeat (DEB - 1) @(posedge clk);
		ignitionWakeIn <= 1'b0;
		tick(5);
		chk("ignShort", ST_SLEEP, modeState);
		ignitionWakeIn <= 1'b1;
		wakeChk(2'h2);
		ignitionWakeIn <= 1'b0;
		goSleep();
		linAbovePreHigh <= 1'b0;
		tick(3);
		chk("monOn", 1, linRxMonitor);
		linDominant <= 1'b1;
		repeat (BUS + 1) @(posedge clk);
		linDominant <= 1'b0;
		wakeChk(2'h3);
		linAbovePreHigh <= 1'b1;
		goSleep();
		linAbovePreHigh <= 1'b0;
		linDominant <= 1'b1;
		tick(MON + 5);
		chk("monShort", 5'h04, {linRxMonitor, modeState});
		linDominant <= 1'b0;
		linAbovePreHigh <= 1'b1;
		wakeChk(2'h3);
		goSleep();
		linAbovePreHigh <= 1'b0;
		tick(MON + 5);
		chk("monFloat", 5'h04, {linRxMonitor, modeState});
		linDominant <= 1'b1;
		repeat (BUS + 1) @(posedge clk);
		linDominant <= 1'b0;
		tick(5);
		chk("lockNoWake", ST_SLEEP, modeState);
		linAbovePreHigh <= 1'b1;
		tick(5);
		chk("rearmNoWake", ST_SLEEP, modeState);
		// supply loss and return with the strap low: defaults, watchdog runs
		dividerPinLevel <= 1'b0;
		supplyOk <= 1'b0;
		tick(2);
		chk("supplyOff", 4'h0, {modeState, regulatorEnable});
		supplyOk <= 1'b1;
		bootChk();
		chk("strapWd", 4'h1, {linTransceiverEnable, switchIfEnable, activeLowPower, watchdogRun});
		chk("pinDrive", 0, {resetOutNOut, irqOutNOut, irqOutNOe});
		summarize();
	end
endmodule : swm_sleep_wake_ctrl_tb_top
`default_nettype wire
